// ==== lxcc_top.sv ====
// Digital control and status logic for the line transceiver comparators and amplifier.
`timescale 1ns/1ps
module lxcc_top
    import lxcc_pkg::*;
(
    input  wire logic          mclk,
    input  wire logic          arst_n,
    input  wire logic          ce,
    input  wire logic          wb_cyc_i,
    input  wire logic          wb_stb_i,
    input  wire logic          wb_we_i,
    input  wire logic [4:0]    wb_adr_i,
    input  wire logic [3:0]    wb_sel_i,
    input  wire logic [31:0]   wb_dat_i,
    output logic      [31:0]   wb_dat_o,
    output logic               wb_ack_o,
    input  wire logic          cmp_zero_decision,
    input  wire logic          cmp_one_decision,
    input  wire logic          amp_out_level,
    output lxcc_cmp_ana_t      cmp_zero_ana,
    output lxcc_cmp_ana_t      cmp_one_ana,
    output lxcc_amp_ana_t      amp_ana,
    output logic               cmp_result_out
);

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic [7:0]  ctl_ff [2];
    logic [7:0]  ctrim_ff [2];
    logic [7:0]  ph_ff;
    logic [7:0]  actl_ff;
    logic [7:0]  atrim_ff;
    logic        amp_status_ff;
    logic        ack_ff;
    logic [31:0] rdat_ff;
    logic        sel_out_ff;
    logic [1:0]  raw_w;
    logic [1:0]  filt_w;
    logic [1:0]  inv_w;
    logic [1:0]  dec_w;
    logic [6:0]  cnt_w [2];

    wire        req    = wb_cyc_i & wb_stb_i & ~ack_ff;
    wire        wr_stb = req & wb_we_i & wb_sel_i[0];
    wire        wr_c0  = wr_stb & (wb_adr_i == OFS_CMP_ZERO_CTL);
    wire        wr_c1  = wr_stb & (wb_adr_i == OFS_CMP_ONE_CTL);
    wire        wr_t0  = wr_stb & (wb_adr_i == OFS_CMP_ZERO_TRIM);
    wire        wr_t1  = wr_stb & (wb_adr_i == OFS_CMP_ONE_TRIM);
    wire        wr_ph  = wr_stb & (wb_adr_i == OFS_CMP_POL_HYS);
    wire        wr_ac  = wr_stb & (wb_adr_i == OFS_AMP_CTL);
    wire        wr_at  = wr_stb & (wb_adr_i == OFS_AMP_TRIM);
    wire [7:0]  wbyte  = wb_dat_i[7:0];

    // Status bits are merged in at read time so stored copies never go stale.
    wire [7:0] rd_c0 = ctl_ff[0] | {raw_w[0], 1'b0, filt_w[0], 5'h00};
    wire [7:0] rd_c1 = ctl_ff[1] | {raw_w[1], 1'b0, filt_w[1], 5'h00};
    wire [7:0] rd_ac = actl_ff | {2'b00, amp_status_ff, 5'h00};
    wire [7:0] rd_byte =
        (wb_adr_i == OFS_CMP_ZERO_CTL)  ? rd_c0 :
        (wb_adr_i == OFS_CMP_ONE_CTL)   ? rd_c1 :
        (wb_adr_i == OFS_CMP_ZERO_TRIM) ? ctrim_ff[0] :
        (wb_adr_i == OFS_CMP_ONE_TRIM)  ? ctrim_ff[1] :
        (wb_adr_i == OFS_CMP_POL_HYS)   ? ph_ff :
        (wb_adr_i == OFS_AMP_CTL)       ? rd_ac :
        (wb_adr_i == OFS_AMP_TRIM)      ? atrim_ff : 8'h00;

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ack_ff  <= 1'b0;
            rdat_ff <= 32'h0000_0000;
        end
        else if (ce)
        begin
            ack_ff  <= req;
            rdat_ff <= {24'h00_0000, rd_byte};
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctl_ff[0]   <= CTL_RST;
            ctl_ff[1]   <= CTL_RST;
            ctrim_ff[0] <= CTRIM_RST;
            ctrim_ff[1] <= CTRIM_RST;
            ph_ff       <= PH_RST;
            actl_ff     <= ACTL_RST;
            atrim_ff    <= ATRIM_RST;
        end
        else if (ce)
        begin
            if (wr_c0) ctl_ff[0] <= wbyte & CTL_WMASK;
            if (wr_c1) ctl_ff[1] <= wbyte & CTL_WMASK;
            if (wr_t0) ctrim_ff[0] <= wbyte & CTRIM_WMASK;
            if (wr_t1) ctrim_ff[1] <= wbyte & CTRIM_WMASK;
            if (wr_ph) ph_ff <= wbyte & PH_WMASK;
            if (wr_ac) actl_ff <= wbyte & ACTL_WMASK;
            if (wr_at) atrim_ff <= wbyte & ATRIM_WMASK;
        end
    end

    // ------------------------------------------------------------------
    // Comparator raw and filtered results
    // ------------------------------------------------------------------
    assign inv_w = {ph_ff[PH_INV_ONE_BIT], ph_ff[PH_INV_ZERO_BIT]};
    assign dec_w = {cmp_one_decision, cmp_zero_decision};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_cmp
            logic             raw_ff;
            logic             filt_ff;
            logic [DEB_W-1:0] cnt_ff;
            wire              en     = ctl_ff[gi][CTL_EN_BIT];
            wire              active = ~inv_w[gi];
            wire [1:0]        len    = ctl_ff[gi][3:2];
            wire [DEB_W-1:0]  lim    = (len == 2'b00) ? DEB_NONE :
                                       (len == 2'b01) ? DEB_SHORT :
                                       (len == 2'b10) ? DEB_MID : DEB_LONG;
            wire              nxt_raw  = en & (dec_w[gi] ^ inv_w[gi]);
            wire              hit      = (raw_ff == active);
            wire              stable   = hit & (cnt_ff >= lim);
            wire [DEB_W-1:0]  nxt_cnt  = !hit ? DEB_NONE :
                                         (cnt_ff == DEB_SAT) ? cnt_ff :
                                         cnt_ff + 7'h01;

            always_ff @(posedge mclk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    raw_ff  <= 1'b0;
                    filt_ff <= 1'b0;
                    cnt_ff  <= DEB_NONE;
                end
                else if (ce)
                begin
                    raw_ff  <= nxt_raw;
                    cnt_ff  <= nxt_cnt;
                    filt_ff <= inv_w[gi] ^ stable;
                end
            end

            assign raw_w[gi]  = raw_ff;
            assign filt_w[gi] = filt_ff;
            assign cnt_w[gi]  = cnt_ff;
        end
    endgenerate

    // ------------------------------------------------------------------
    // Result select and amplifier status
    // ------------------------------------------------------------------
    wire nxt_sel_out = ph_ff[PH_SEL_BIT] ? filt_w[1] : filt_w[0];
    // The level is only meaningful in calibration, so normal mode reads low.
    wire nxt_amp_status = atrim_ff[ATRIM_MODE_BIT] & amp_out_level;

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sel_out_ff    <= 1'b0;
            amp_status_ff <= 1'b0;
        end
        else if (ce)
        begin
            sel_out_ff    <= nxt_sel_out;
            amp_status_ff <= nxt_amp_status;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign wb_ack_o       = ack_ff;
    assign wb_dat_o       = rdat_ff;
    assign cmp_result_out = sel_out_ff;

    assign cmp_zero_ana.enable         = ctl_ff[0][CTL_EN_BIT];
    assign cmp_zero_ana.bias_sel       = ctl_ff[0][1:0];
    assign cmp_zero_ana.hysteresis_sel = ph_ff[1:0];
    assign cmp_zero_ana.cal_mode       = ctrim_ff[0][CTRIM_MODE_BIT];
    assign cmp_zero_ana.cal_ref_sel    = ctrim_ff[0][CTRIM_REF_BIT];
    assign cmp_zero_ana.offset_trim    = ctrim_ff[0][4:0];
    assign cmp_one_ana.enable          = ctl_ff[1][CTL_EN_BIT];
    assign cmp_one_ana.bias_sel        = ctl_ff[1][1:0];
    assign cmp_one_ana.hysteresis_sel  = ph_ff[3:2];
    assign cmp_one_ana.cal_mode        = ctrim_ff[1][CTRIM_MODE_BIT];
    assign cmp_one_ana.cal_ref_sel     = ctrim_ff[1][CTRIM_REF_BIT];
    assign cmp_one_ana.offset_trim     = ctrim_ff[1][4:0];
    // Disabled amplifier output toggles every cycle in the analog model.
    assign amp_ana.enable              = actl_ff[ACTL_EN_BIT];
    assign amp_ana.bandwidth_sel       = actl_ff[ACTL_BW_BIT];
    assign amp_ana.cal_mode            = atrim_ff[ATRIM_MODE_BIT];
    assign amp_ana.cal_ref_sel         = atrim_ff[ATRIM_REF_BIT];
    assign amp_ana.offset_trim         = atrim_ff[5:0];

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    sequence s_wr(logic [4:0] a);
        ce && wb_cyc_i && wb_stb_i && wb_we_i && !ack_ff && wb_sel_i[0] && wb_adr_i == a;
    endsequence

    property p_raw;
        (ce && cmp_one_ana.enable) |=> (raw_w[1] == $past(cmp_one_decision ^ inv_w[1]));
    endproperty
    a_raw: assert property (p_raw) else $error("raw output wrong");

    property p_dis;
        (ce && !cmp_one_ana.enable) |=> (raw_w[1] == 1'b0);
    endproperty
    a_dis: assert property (p_dis) else $error("disabled raw not zero");

    property p_deb;
        (ce && filt_w[1] == 1'b0 && inv_w[1] == 1'b0) ##1 (ce && filt_w[1] == 1'b1)
            |-> $past(cnt_w[1]) >= ((ctl_ff[1][3:2] == 2'b00) ? 7'h00 : 7'h1f);
    endproperty
    a_deb: assert property (p_deb) else $error("filter rose too early");

    property p_len;
        (ce && ctl_ff[1][3:2] == 2'b11 && !inv_w[1] && raw_w[1] && cnt_w[1] < 7'h7e)
            |=> (filt_w[1] == 1'b0);
    endproperty
    a_len: assert property (p_len) else $error("long filter too short");

    property p_rst;
        (ce && raw_w[1] == inv_w[1]) |=> (cnt_w[1] == 7'h00);
    endproperty
    a_rst: assert property (p_rst) else $error("count not restarted");

    property p_trim;
        s_wr(OFS_CMP_ONE_TRIM) |=> (cmp_one_ana.offset_trim == $past(wb_dat_i[4:0]))
            && (cmp_one_ana.cal_mode == $past(wb_dat_i[6]));
    endproperty
    a_trim: assert property (p_trim) else $error("trim write lost");

    property p_sel;
        ce |=> (cmp_result_out == $past(ph_ff[6] ? filt_w[1] : filt_w[0]));
    endproperty
    a_sel: assert property (p_sel) else $error("result select wrong");

    property p_amp_en;
        s_wr(OFS_AMP_CTL) |=> (amp_ana.enable == $past(wb_dat_i[6]))
            && (amp_ana.bandwidth_sel == $past(wb_dat_i[0]));
    endproperty
    a_amp_en: assert property (p_amp_en) else $error("amp control write lost");

    property p_amp_st;
        (ce && !amp_ana.cal_mode) |=> (amp_status_ff == 1'b0);
    endproperty
    a_amp_st: assert property (p_amp_st) else $error("amp status not low");

    property p_zero;
        (ce && req && !wb_we_i) |=> wb_ack_o && (wb_dat_o[31:8] == 24'h00_0000)
            && (wb_adr_i != OFS_CMP_ONE_CTL || wb_dat_o[4] == 1'b0);
    endproperty
    a_zero: assert property (p_zero) else $error("unused bits not zero");

endmodule // lxcc_top

// ==== lxcc_pkg.sv ====
// Package of constants and carrier types for the line transceiver analog control block.
package lxcc_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [4:0] OFS_CMP_ZERO_CTL   = 5'h00;
    localparam logic [4:0] OFS_CMP_ONE_CTL    = 5'h04;
    localparam logic [4:0] OFS_CMP_ZERO_TRIM  = 5'h08;
    localparam logic [4:0] OFS_CMP_ONE_TRIM   = 5'h0c;
    localparam logic [4:0] OFS_CMP_POL_HYS    = 5'h10;
    localparam logic [4:0] OFS_AMP_CTL        = 5'h14;
    localparam logic [4:0] OFS_AMP_TRIM       = 5'h18;

    // ------------------------------------------------------------------
    // Field positions and write masks
    // ------------------------------------------------------------------
    localparam int CTL_RAW_BIT     = 7;
    localparam int CTL_EN_BIT      = 6;
    localparam int CTL_FILT_BIT    = 5;
    localparam int CTRIM_MODE_BIT  = 6;
    localparam int CTRIM_REF_BIT   = 5;
    localparam int PH_SEL_BIT      = 6;
    localparam int PH_INV_ONE_BIT  = 5;
    localparam int PH_INV_ZERO_BIT = 4;
    localparam int ACTL_EN_BIT     = 6;
    localparam int ACTL_STAT_BIT   = 5;
    localparam int ACTL_BW_BIT     = 0;
    localparam int ATRIM_MODE_BIT  = 7;
    localparam int ATRIM_REF_BIT   = 6;
    localparam logic [7:0] CTL_WMASK   = 8'h4f;
    localparam logic [7:0] CTRIM_WMASK = 8'h7f;
    localparam logic [7:0] PH_WMASK    = 8'h7f;
    localparam logic [7:0] ACTL_WMASK  = 8'h41;
    localparam logic [7:0] ATRIM_WMASK = 8'hff;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] CTL_RST   = 8'h00;
    localparam logic [7:0] CTRIM_RST = 8'h10;
    localparam logic [7:0] PH_RST    = 8'h00;
    localparam logic [7:0] ACTL_RST  = 8'h00;
    localparam logic [7:0] ATRIM_RST = 8'h20;

    // ------------------------------------------------------------------
    // Debounce lengths in system clocks
    // ------------------------------------------------------------------
    localparam int         DEB_W     = 7;
    localparam logic [6:0] DEB_NONE  = 7'h00;
    localparam logic [6:0] DEB_SHORT = 7'h1f;
    localparam logic [6:0] DEB_MID   = 7'h3f;
    localparam logic [6:0] DEB_LONG  = 7'h7e;
    localparam logic [6:0] DEB_SAT   = 7'h7f;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       enable;
        logic [1:0] bias_sel;
        logic [1:0] hysteresis_sel;
        logic       cal_mode;
        logic       cal_ref_sel;
        logic [4:0] offset_trim;
    } lxcc_cmp_ana_t;

    typedef struct packed {
        logic       enable;
        logic       bandwidth_sel;
        logic       cal_mode;
        logic       cal_ref_sel;
        logic [5:0] offset_trim;
    } lxcc_amp_ana_t;

endpackage

// ==== lxcc_ana_model.sv ====
// Behavioural model of the analog comparators and amplifier behind the control block.
`timescale 1ns/1ps
module lxcc_ana_model
    import lxcc_pkg::*;
#(
    parameter int CMP_TRIP = 13,
    parameter int AMP_TRIP = 40
)
(
    input  wire logic          mclk,
    input  wire lxcc_cmp_ana_t cmp_zero_ana,
    input  wire lxcc_cmp_ana_t cmp_one_ana,
    input  wire lxcc_amp_ana_t amp_ana,
    input  wire logic          line_zero,
    input  wire logic          line_one,
    input  wire logic          amp_line,
    output logic               cmp_zero_decision,
    output logic               cmp_one_decision,
    output logic               amp_out_level
);
    // ------------------------------------------------------------------
    // Decisions
    // ------------------------------------------------------------------
    // The trip point stands for an unknown input offset that the trim cancels.
    // A switched-off stage gives no usable level, so it toggles every cycle.
    initial
    begin
        cmp_zero_decision = 1'b0;
        cmp_one_decision  = 1'b0;
        amp_out_level     = 1'b0;
    end

    always @(posedge mclk)
    begin
        if (!cmp_zero_ana.enable)
            cmp_zero_decision <= ~cmp_zero_decision;
        else
            cmp_zero_decision <= line_zero;
        if (!cmp_one_ana.enable)
            cmp_one_decision <= ~cmp_one_decision;
        else if (cmp_one_ana.cal_mode)
            cmp_one_decision <= (int'(cmp_one_ana.offset_trim) >= CMP_TRIP);
        else
            cmp_one_decision <= line_one;
        if (!amp_ana.enable)
            amp_out_level <= ~amp_out_level;
        else if (amp_ana.cal_mode)
            amp_out_level <= (int'(amp_ana.offset_trim) >= AMP_TRIP);
        else
            amp_out_level <= amp_line;
    end
endmodule // lxcc_ana_model

// ==== testbench.sv ====
// Self-checking testbench for the line transceiver analog control block.
`timescale 1ns/1ps
module testbench
    import lxcc_pkg::*;
;
    localparam int CTRIP = 13;
    localparam int ATRIP = 40;
    logic          mclk, arst_n, ce;
    logic          wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [4:0]    wb_adr_i;
    logic [3:0]    wb_sel_i;
    logic [31:0]   wb_dat_i, wb_dat_o, rd;
    logic          cz_dec, co_dec, amp_lvl, line0, line1, aline, cmp_result_out;
    lxcc_cmp_ana_t cz_ana, co_ana;
    lxcc_amp_ana_t amp_ana;
    logic [7:0]    res;
    int            bad_count, cmp_count, cycles, n;
    int            deb_n [4]     = '{0, 31, 63, 126};
    logic [7:0]    rst_tab [8]   = '{8'h00, 8'h00, 8'h10, 8'h10, 8'h00, 8'h00, 8'h20, 8'h00};
    logic [7:0]    mask_tab [8]  = '{8'h4f, 8'h4f, 8'h7f, 8'h7f, 8'h7f, 8'h41, 8'hff, 8'h00};

    lxcc_top dut (.mclk(mclk), .arst_n(arst_n), .ce(ce), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .cmp_zero_decision(cz_dec), .cmp_one_decision(co_dec), .amp_out_level(amp_lvl),
        .cmp_zero_ana(cz_ana), .cmp_one_ana(co_ana), .amp_ana(amp_ana),
        .cmp_result_out(cmp_result_out));
    lxcc_ana_model #(.CMP_TRIP(CTRIP), .AMP_TRIP(ATRIP)) ana (.mclk(mclk),
        .cmp_zero_ana(cz_ana), .cmp_one_ana(co_ana), .amp_ana(amp_ana), .line_zero(line0),
        .line_one(line1), .amp_line(aline), .cmp_zero_decision(cz_dec),
        .cmp_one_decision(co_dec), .amp_out_level(amp_lvl));

    // ------------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ------------------------------------------------------------------
    always #4 mclk = ~mclk;
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            final_report();
        end
    end

    task automatic final_report;
        $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One classic cycle; the request stands until ack is sampled high.
    task automatic wb_xfer(input logic we, input logic [4:0] adr, input logic [7:0] wd);
        int k;
        k = 0;
        @(posedge mclk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'h1;
        wb_dat_i <= {24'h000000, wd};
        do
        begin
            @(posedge mclk);
            k++;
        end
        while (wb_ack_o !== 1'b1 && k < 50);
        if (k >= 50)
            bad_count++;
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic expect_reg(input logic [4:0] adr, input logic [7:0] exp);
        wb_xfer(1'b0, adr, 8'h00);
        check(rd, {24'h000000, exp});
    endtask

    // Write a trim, let the analog result settle through the pipeline, read status.
    task automatic probe(input logic [4:0] tadr, sadr, input logic [7:0] v, input int sb,
                         output logic s);
        wb_xfer(1'b1, tadr, v);
        repeat (4) @(posedge mclk);
        wb_xfer(1'b0, sadr, 8'h00);
        s = rd[sb];
    endtask

    task automatic cal_search(input logic [4:0] tadr, sadr, input int sb,
                              input logic [7:0] mode, top, output logic [7:0] avg);
        logic [7:0] t, p1;
        logic       first, s;
        t = 8'h00;
        probe(tadr, sadr, mode | t, sb, first);
        do
        begin
            t++;
            probe(tadr, sadr, mode | t, sb, s);
        end
        while (s === first && t < top);
        p1 = t;
        t = top;
        probe(tadr, sadr, mode | t, sb, first);
        do
        begin
            t--;
            probe(tadr, sadr, mode | t, sb, s);
        end
        while (s === first && t > 8'h00);
        avg = (p1 + t) >> 1;
        wb_xfer(1'b1, tadr, mode | avg);
    endtask

    task automatic drive_line(input logic sel, input logic v);
        if (sel)
            line1 <= v;
        else
            line0 <= v;
    endtask

    // Cycles from the input turning active until the selected result goes high.
    task automatic filt_time(input logic sel, input logic [1:0] code, input logic glitch,
                             output int cnt);
        drive_line(1'b0, 1'b0);
        drive_line(1'b1, 1'b0);
        wb_xfer(1'b1, sel ? OFS_CMP_ONE_CTL : OFS_CMP_ZERO_CTL, {4'h4, code, 2'b00});
        wb_xfer(1'b1, OFS_CMP_POL_HYS, {1'b0, sel, 6'h00});
        repeat (140) @(posedge mclk);
        if (glitch)
        begin
            drive_line(sel, 1'b1);
            repeat (25) @(posedge mclk);
            drive_line(sel, 1'b0);
            @(posedge mclk);
        end
        drive_line(sel, 1'b1);
        cnt = 0;
        while (cmp_result_out !== 1'b1 && cnt < 300)
        begin
            @(posedge mclk);
            cnt++;
        end
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        mclk = 1'b0; arst_n = 1'b0; ce = 1'b1; wb_cyc_i = 1'b0; wb_stb_i = 1'b0;
        wb_we_i = 1'b0; wb_adr_i = 5'h00; wb_sel_i = 4'h0; wb_dat_i = 32'h0;
        line0 = 1'b0; line1 = 1'b0; aline = 1'b1;
        bad_count = 0; cmp_count = 0; cycles = 0;
        repeat (8) @(posedge mclk);
        arst_n <= 1'b1;
        for (int i = 0; i < 8; i++)
            expect_reg(5'(i * 4), rst_tab[i]);
        for (int i = 0; i < 8; i++)
        begin
            wb_xfer(1'b1, 5'(i * 4), 8'hff);
            expect_reg(5'(i * 4), mask_tab[i]);
        end
        check({20'h0, co_ana}, {20'h0, 1'b1, 2'b11, 2'b11, 1'b1, 1'b1, 5'h1f});
        check({20'h0, cz_ana}, {20'h0, 1'b1, 2'b11, 2'b11, 1'b1, 1'b1, 5'h1f});
        check({22'h0, amp_ana}, {22'h0, 1'b1, 1'b1, 1'b1, 1'b1, 6'h3f});
        wb_xfer(1'b1, OFS_AMP_TRIM, 8'h20);
        wb_xfer(1'b1, OFS_AMP_CTL, 8'h41);
        repeat (4) @(posedge mclk);
        expect_reg(OFS_AMP_CTL, 8'h41);
        // Comparator one must leave calibration mode, or its decision ignores the line.
        wb_xfer(1'b1, OFS_CMP_ONE_TRIM, 8'h10);
        for (int k = 0; k < 8; k++)
        begin
            line0 <= k[0];
            line1 <= k[0];
            wb_xfer(1'b1, OFS_CMP_POL_HYS, {2'b00, k[1], k[1], 4'h0});
            wb_xfer(1'b1, OFS_CMP_ONE_CTL, {1'b0, k[2], 6'h00});
            wb_xfer(1'b1, OFS_CMP_ZERO_CTL, {1'b0, k[2], 6'h00});
            repeat (3) @(posedge mclk);
            wb_xfer(1'b0, OFS_CMP_ONE_CTL, 8'h00);
            check(rd[7], k[2] & (k[0] ^ k[1]));
            wb_xfer(1'b0, OFS_CMP_ZERO_CTL, 8'h00);
            check(rd[7], k[2] & (k[0] ^ k[1]));
        end
        for (int c = 0; c < 4; c++)
        begin
            filt_time(1'b1, 2'(c), 1'b0, n);
            check(n >= deb_n[c] + 1 && n <= deb_n[c] + 6, 1);
        end
        filt_time(1'b1, 2'b01, 1'b1, n);
        check(n >= 32 && n <= 37, 1);
        filt_time(1'b0, 2'b11, 1'b0, n);
        check(n >= 127 && n <= 132, 1);
        wb_xfer(1'b1, OFS_CMP_POL_HYS, 8'h40);
        repeat (3) @(posedge mclk);
        check(cmp_result_out, 1'b0);
        // With the clock enable low the filter must not see the active input at all.
        ce    <= 1'b0;
        line1 <= 1'b1;
        repeat (50) @(posedge mclk);
        check(cmp_result_out, 1'b0);
        ce    <= 1'b1;
        repeat (40) @(posedge mclk);
        check(cmp_result_out, 1'b1);
        wb_xfer(1'b1, OFS_CMP_ONE_CTL, 8'h40);
        wb_xfer(1'b1, OFS_CMP_ONE_TRIM, 8'h70);
        cal_search(OFS_CMP_ONE_TRIM, OFS_CMP_ONE_CTL, 7, 8'h60, 8'h1f, res);
        expect_reg(OFS_CMP_ONE_TRIM, 8'h60 | 8'((CTRIP + CTRIP - 1) / 2));
        wb_xfer(1'b1, OFS_AMP_TRIM, 8'he0);
        cal_search(OFS_AMP_TRIM, OFS_AMP_CTL, 5, 8'hc0, 8'h3f, res);
        expect_reg(OFS_AMP_TRIM, 8'hc0 | 8'((ATRIP + ATRIP - 1) / 2));
        final_report();
    end
endmodule // testbench
